//--- design/spi_master_slave_port.v
// serial port in spi mode: master or slave byte exchange with status bits
`default_nettype none
`include "spi_port_map.vh"
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - a received byte goes to the data buffer, then buffer-full and flag set
// - transmit is unbuffered: a data write loads buffer and shift register
// - control low six bits and status top two bits pick the operating options
// - status low six bits read-only, top two read/write, control all read/write
// - serial pins claimed only while enabled; reconfigure by disable, write, enable
// - reading the data buffer clears buffer-full
// - data write during shifting is dropped and sets write-collision
// - master starts on data write and samples input while its data output stays driven
// - master bit rate: clock/4, /16, /64, timer/2 or clock/(4*(reload+1))
// - with edge select set, output data is valid before first clock edge
// - shift most significant bit first, in and out
// - slave shifts one bit per external pulse, flags on last bit latched
// - slave keeps shifting from the clock pin sample; flag sets after the last bit
// - overwrite enable lets data writes through with an unread byte
// - mode code 0100 gives slave operation with slave-select control
// - with slave-select control, shift and drive output only while select low
// - select going high releases the serial output at once
// - select high under control, or enable cleared, zeroes the bit counter
// - slave with edge select set must use slave-select control
// - slave role ignores the sample-phase bit, which keeps its written value
// - slave output changes on the programmed edge, input captured on the other; master output always changes on the trailing edge
//////////////////////////////////////////////////////////////////////////////
module spi_master_slave_port #(
  parameter RELOAD_W = 8
) (
  // clock and reset
  input  wire                core_clk,
  input  wire                rst,
  // software access
  input  wire                ctl_wr,
  input  wire [7:0]          ctl_wdata,
  input  wire                sta_wr,
  input  wire [7:0]          sta_wdata,
  input  wire                ctl3_wr,
  input  wire [7:0]          ctl3_wdata,
  input  wire                rate_wr,
  input  wire [RELOAD_W-1:0] rate_wdata,
  input  wire                buf_wr,
  input  wire [7:0]          buf_wdata,
  input  wire                buf_rd,
  input  wire                flag_clr,
  input  wire                timer_tick,
  // register views
  output reg  [7:0]          port_control_reg_one,
  output reg  [7:0]          port_status_reg,
  output reg  [7:0]          port_control_reg_three,
  output reg  [RELOAD_W-1:0] rate_reload_value,
  output reg  [7:0]          port_data_buffer,
  output reg                 port_interrupt_flag,
  // received byte stream
  output reg                 rx_valid,
  input  wire                rx_ready,
  output reg  [7:0]          rx_data,
  // serial pins
  input  wire                serial_clock_in,
  output reg                 serial_clock_out,
  output reg                 serial_clock_oe,
  input  wire                serial_data_input,
  output reg                 serial_data_output,
  output reg                 serial_data_oe,
  input  wire                slave_select_input
);
  reg  [7:0]          serial_shift_register;
  reg  [2:0]          bit_count;
  reg                 busy;
  reg                 sck_prev;
  reg                 ss_prev;
  reg                 sample_bit;
  reg                 sample_pending;
  reg                 phase;
  reg  [RELOAD_W+1:0] div_count;
  reg  [RELOAD_W+1:0] half_limit;
  reg                 tick;
  reg                 done;
  reg  [7:0]          done_byte;
  wire                enable;
  wire                cke;
  wire                clock_polarity_bit;
  wire                input_sample_phase_bit;
  wire [3:0]          mode;
  wire                master;
  wire                ss_ctl;
  wire                ss_active;
  wire                ss_rise;
  wire                port_reset;
  wire                sck_rise;
  wire                sck_fall;
  wire                lead_edge;
  wire                trail_edge;
  wire                write_ok;
  wire                sbuf_ready;
  wire                sbuf_valid;
  wire [7:0]          sbuf_data;

  //////////////////////////////////////////////////////////////////////////////
  // option decode
  assign enable  = port_control_reg_one[`CTL_EN_BIT];
  assign clock_polarity_bit     = port_control_reg_one[`CTL_CKP_BIT];
  assign mode    = port_control_reg_one[`CTL_MODE_HI:`CTL_MODE_LO];
  assign cke     = port_status_reg[`STA_CKE_BIT];
  assign input_sample_phase_bit     = port_status_reg[`STA_SMP_BIT];
  assign master  = (mode != `MODE_S_SS) && (mode != `MODE_S_NOSS);
  assign ss_ctl  = (mode == `MODE_S_SS) | (~master & cke);
  assign ss_active  = ~ss_ctl | ~slave_select_input;
  assign ss_rise    = ss_ctl & slave_select_input & ~ss_prev;
  assign port_reset = ~enable | ss_rise;

  // slave edges seen on the synchronous clock pin sample
  assign sck_rise   = serial_clock_in & ~sck_prev;
  assign sck_fall   = ~serial_clock_in & sck_prev;
  // leading edge leaves idle level; trailing edge returns to it
  assign lead_edge  = clock_polarity_bit ? sck_fall : sck_rise;
  assign trail_edge = clock_polarity_bit ? sck_rise : sck_fall;

  assign write_ok = ~busy & ~port_control_reg_one[`CTL_WRITE_COLLISION_BIT_BIT] &
                    (~port_status_reg[`STA_BF_BIT] |
                     port_control_reg_three[`CTL3_BUFFER_OVERWRITE_ENABLE_BIT]);

  //////////////////////////////////////////////////////////////////////////////
  // master rate select
  always @*
  begin
    case (mode)
      `MODE_M_DIV4:   half_limit = {{(RELOAD_W-6){1'b0}}, `HALF_DIV4};
      `MODE_M_DIV16:  half_limit = {{(RELOAD_W-6){1'b0}}, `HALF_DIV16};
      `MODE_M_DIV64:  half_limit = {{(RELOAD_W-6){1'b0}}, `HALF_DIV64};
      `MODE_M_RELOAD: half_limit = {1'b0, rate_reload_value, 1'b1};
      default:        half_limit = {{(RELOAD_W-6){1'b0}}, `HALF_DIV4};
    endcase
  end

  // one tick per half bit period
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      div_count <= {(RELOAD_W+2){1'b0}};
      tick      <= 1'b0;
    end
    else if (~busy | ~master)
    begin
      div_count <= {(RELOAD_W+2){1'b0}};
      tick      <= 1'b0;
    end
    else if (mode == `MODE_M_TMR)
    begin
      tick <= timer_tick;
    end
    else if (div_count >= half_limit)
    begin
      div_count <= {(RELOAD_W+2){1'b0}};
      tick      <= 1'b1;
    end
    else
    begin
      div_count <= div_count + {{(RELOAD_W+1){1'b0}}, 1'b1};
      tick      <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers, shifter and status
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      port_control_reg_one   <= `RESET_BYTE;
      port_status_reg        <= `RESET_BYTE;
      port_control_reg_three <= `RESET_BYTE;
      rate_reload_value      <= {RELOAD_W{1'b0}};
      port_data_buffer       <= `RESET_BYTE;
      port_interrupt_flag    <= 1'b0;
      serial_shift_register  <= `RESET_BYTE;
      bit_count              <= `BIT_COUNT_ZERO;
      busy                   <= 1'b0;
      sck_prev               <= 1'b0;
      ss_prev                <= 1'b1;
      sample_bit             <= 1'b0;
      sample_pending         <= 1'b0;
      phase                  <= 1'b0;
      done                   <= 1'b0;
      done_byte              <= `RESET_BYTE;
      serial_clock_out       <= 1'b0;
    end
    else
    begin
      sck_prev <= serial_clock_in;
      ss_prev  <= slave_select_input;
      done     <= 1'b0;
      // configuration writes
      if (ctl_wr)
      begin
        if (enable & ctl_wdata[`CTL_EN_BIT])
          port_control_reg_one[`CTL_EN_BIT] <= 1'b1;
        else
          port_control_reg_one <= ctl_wdata;
      end
      if (sta_wr & ~enable)
        port_status_reg[`STA_SMP_BIT:`STA_CKE_BIT] <= sta_wdata[`STA_SMP_BIT:`STA_CKE_BIT];
      if (ctl3_wr & ~enable)
        port_control_reg_three <= ctl3_wdata;
      if (rate_wr & ~enable)
        rate_reload_value <= rate_wdata;
      if (flag_clr)
        port_interrupt_flag <= 1'b0;
      if (buf_rd)
        port_status_reg[`STA_BF_BIT] <= 1'b0;
      // data write
      if (buf_wr & enable)
      begin
        if (write_ok)
        begin
          port_data_buffer      <= buf_wdata;
          serial_shift_register <= buf_wdata;
          busy                  <= master;
        end
        else if (busy)
          port_control_reg_one[`CTL_WRITE_COLLISION_BIT_BIT] <= 1'b1;
      end
      // idle clock level follows polarity
      if (~busy | ~master)
        serial_clock_out <= clock_polarity_bit;
      // shifting
      if (port_reset)
      begin
        bit_count      <= `BIT_COUNT_ZERO;
        busy           <= 1'b0;
        sample_pending <= 1'b0;
        phase          <= 1'b0;
        serial_clock_out <= clock_polarity_bit;
      end
      else if (master & busy & tick)
      begin
        serial_clock_out <= ~serial_clock_out;
        phase            <= ~phase;
        // phase 0 edge: capture unless smp moves it; phase 1: shift
        if (~phase)
        begin
          sample_bit <= serial_data_input;
        end
        else
        begin
          serial_shift_register <= {serial_shift_register[6:0],
                                    input_sample_phase_bit ? serial_data_input : sample_bit};
          bit_count <= bit_count + 3'h1;
          if (bit_count == `BIT_COUNT_LAST)
          begin
            busy <= 1'b0;
            done <= 1'b1;
            done_byte <= {serial_shift_register[6:0],
                          input_sample_phase_bit ? serial_data_input : sample_bit};
          end
        end
      end
      else if (~master & ss_active)
      begin
        if ((cke ? lead_edge : trail_edge))
        begin
          sample_bit     <= serial_data_input;
          sample_pending <= 1'b1;
          busy           <= 1'b1;
          if (bit_count == `BIT_COUNT_LAST)
          begin
            serial_shift_register <= {serial_shift_register[6:0], serial_data_input};
            bit_count      <= `BIT_COUNT_ZERO;
            busy           <= 1'b0;
            sample_pending <= 1'b0;
            done           <= 1'b1;
            done_byte      <= {serial_shift_register[6:0], serial_data_input};
          end
        end
        else if ((cke ? trail_edge : lead_edge) & sample_pending)
        begin
          serial_shift_register <= {serial_shift_register[6:0], sample_bit};
          bit_count      <= bit_count + 3'h1;
          sample_pending <= 1'b0;
        end
      end
      // byte complete: buffer then status
      if (done)
      begin
        port_data_buffer             <= done_byte;
        port_status_reg[`STA_BF_BIT] <= 1'b1;
        port_interrupt_flag          <= 1'b1;
        if (port_status_reg[`STA_BF_BIT] & ~buf_rd)
          port_control_reg_one[`CTL_OVF_BIT] <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin drivers
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      serial_data_output <= 1'b0;
      serial_data_oe     <= 1'b0;
      serial_clock_oe    <= 1'b0;
    end
    else
    begin
      serial_data_output <= serial_shift_register[7];
      serial_data_oe     <= enable & ss_active & ~(ss_ctl & slave_select_input);
      serial_clock_oe    <= enable & master;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // received byte stream through the two-entry buffer
  spi_skid_buffer #(
    .WIDTH (8)
  ) u_rx_buf (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (done),
    .in_ready  (sbuf_ready),
    .in_data   (done_byte),
    .out_valid (sbuf_valid),
    .out_ready (rx_ready | ~rx_valid),
    .out_data  (sbuf_data)
  );

  always @(posedge core_clk)
  begin
    if (rst)
    begin
      rx_valid <= 1'b0;
      rx_data  <= `RESET_BYTE;
    end
    else if (rx_ready | ~rx_valid)
    begin
      rx_valid <= sbuf_valid;
      rx_data  <= sbuf_data;
    end
  end
endmodule // spi_master_slave_port
`default_nettype wire

//--- design/spi_port_map.vh
// constants for the serial port: field positions, mode codes, rate divisors
`ifndef SPI_PORT_MAP_VH
`define SPI_PORT_MAP_VH
// port_control_reg_one fields
`define CTL_WRITE_COLLISION_BIT_BIT     7
`define CTL_OVF_BIT      6
`define CTL_EN_BIT       5
`define CTL_CKP_BIT      4
`define CTL_MODE_HI      3
`define CTL_MODE_LO      0
// port_status_reg fields
`define STA_SMP_BIT      7
`define STA_CKE_BIT      6
`define STA_BF_BIT       0
// port_control_reg_three fields
`define CTL3_BUFFER_OVERWRITE_ENABLE_BIT    4
// port_mode_field codes
`define MODE_M_DIV4      4'h0
`define MODE_M_DIV16     4'h1
`define MODE_M_DIV64     4'h2
`define MODE_M_TMR       4'h3
`define MODE_S_SS        4'h4
`define MODE_S_NOSS      4'h5
`define MODE_M_RELOAD    4'ha
// half-bit counter limits: system clocks per half bit, minus one
`define HALF_DIV4        8'h01
`define HALF_DIV16       8'h07
`define HALF_DIV64       8'h1f
// reset values and last bit count
`define RESET_BYTE       8'h00
`define BIT_COUNT_LAST   3'h7
`define BIT_COUNT_ZERO   3'h0
`endif

//--- design/spi_skid_buffer.v
// two-entry buffer with valid and ready on both sides
`default_nettype none
module spi_skid_buffer #(
  parameter WIDTH = 8
) (
  // clock and reset
  input  wire             core_clk,
  input  wire             rst,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] entry [0:1];
  reg             rd_ptr;
  reg             wr_ptr;
  reg [1:0]       count;
  wire            push;
  wire            pop;

  assign in_ready  = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data  = entry[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge core_clk)
  begin
    if (rst)
    begin
      rd_ptr   <= 1'b0;
      wr_ptr   <= 1'b0;
      count    <= 2'h0;
      entry[0] <= {WIDTH{1'b0}};
      entry[1] <= {WIDTH{1'b0}};
    end
    else
    begin
      if (push)
      begin
        entry[wr_ptr] <= in_data;
        wr_ptr        <= ~wr_ptr;
      end
      if (pop)
        rd_ptr <= ~rd_ptr;
      if (push & ~pop)
        count <= count + 2'h1;
      else if (pop & ~push)
        count <= count - 2'h1;
    end
  end
endmodule // spi_skid_buffer
`default_nettype wire

//--- sim/spi_port_sva.sv
// assertion checker for the spi port, bound to its top module
`default_nettype none
module spi_port_sva (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // software strobes
  input wire logic       ctl_wr,
  input wire logic       buf_rd,
  input wire logic       flag_clr,
  // register views
  input wire logic [7:0] port_control_reg_one,
  input wire logic [7:0] port_status_reg,
  input wire logic       port_interrupt_flag,
  // serial pins
  input wire logic       serial_clock_out,
  input wire logic       serial_clock_oe,
  input wire logic       serial_data_oe,
  input wire logic       slave_select_input
);
  timeunit 1ns;
  timeprecision 1ps;
  logic en;
  logic sel;
  logic div4;
  assign en   = port_control_reg_one[5];
  assign sel  = en && port_control_reg_one[3:0] == 4'h4;
  assign div4 = en && port_control_reg_one[4:0] == 5'h00;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  property p_pins_off;
    (!en) [*2] |-> !serial_data_oe && !serial_clock_oe;
  endproperty
  a_pins_off: assert property (p_pins_off) else $error("pins driven while off");
  property p_div4;
    div4 && $rose(serial_clock_out) |-> serial_clock_out [*2] ##1 !serial_clock_out;
  endproperty
  a_div4: assert property (p_div4) else $error("fast clock high time wrong");
  property p_sel_drive;
    (sel && !slave_select_input) [*4] |-> serial_data_oe;
  endproperty
  a_sel_drive: assert property (p_sel_drive) else $error("output off while selected");
  property p_sel_release;
    sel && $rose(slave_select_input) |-> ##[1:3] !serial_data_oe;
  endproperty
  a_sel_release: assert property (p_sel_release) else $error("output kept after deselect");
  property p_bf_clear;
    buf_rd |-> ##[1:2] !port_status_reg[0];
  endproperty
  a_bf_clear: assert property (p_bf_clear) else $error("buffer full kept after read");
  property p_flag_hold;
    port_interrupt_flag && !flag_clr |=> port_interrupt_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped by itself");
  property p_flag_bf;
    $rose(port_interrupt_flag) |-> port_status_reg[0];
  endproperty
  a_flag_bf: assert property (p_flag_bf) else $error("flag without buffer full");
  property p_write_collision_bit_hold;
    port_control_reg_one[7] && !ctl_wr |=> port_control_reg_one[7];
  endproperty
  a_write_collision_bit_hold: assert property (p_write_collision_bit_hold) else $error("collision bit dropped");
endmodule // spi_port_sva
bind spi_master_slave_port spi_port_sva i_sva (.core_clk, .rst, .ctl_wr, .buf_rd, .flag_clr,
  .port_control_reg_one, .port_status_reg, .port_interrupt_flag, .serial_clock_out,
  .serial_clock_oe, .serial_data_oe, .slave_select_input);
`default_nettype wire

//--- sim/spi_far_end.sv
// far-side spi device: slave to a master port, or master to a slave port
`default_nettype none
module spi_far_end (
  // clock
  input wire logic       core_clk,
  // control
  input wire logic       master_role,
  input wire logic       go,
  input wire logic [3:0] nbits,
  input wire logic [7:0] tx_byte,
  // serial lines
  input wire logic       sck,
  input wire logic       dev_sdo,
  output var logic       sck_drv,
  output var logic       sdo,
  output var logic       ss_n,
  // results
  output var logic [7:0] rx_byte,
  output var logic       busy
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 6;
  logic [7:0] sh;
  initial
  begin
    sck_drv = 1'b0;
    ss_n = 1'b1;
    {sdo, busy, sh, rx_byte} = '0;
  end
  always @(posedge sck)
    rx_byte <= {rx_byte[6:0], dev_sdo};
  always @(negedge sck)
  begin
    sh <= {sh[6:0], 1'b0};
    sdo <= sh[6];
  end
  ////////////////////////////////////////////////////////////
  always @(posedge core_clk)
    if (go)
    begin
      sh <= tx_byte;
      sdo <= tx_byte[7];
      if (master_role)
      begin
        busy = 1'b1;
        ss_n <= 1'b0;
        repeat (HALF) @(posedge core_clk);
        for (int i = 0; i < nbits; i++)
        begin
          sck_drv <= 1'b1;
          repeat (HALF) @(posedge core_clk);
          sck_drv <= 1'b0;
          repeat (HALF) @(posedge core_clk);
        end
        ss_n <= 1'b1;
        sdo <= ~sdo;
        busy = 1'b0;
      end
    end
endmodule // spi_far_end
`default_nettype wire

//--- sim/testbench.sv
// self-checking bench for the spi port
`default_nettype none
`define CHECK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR %0t: got %h want %h", $time, g, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk, rst, ctl_wr, sta_wr, ctl3_wr, rate_wr, buf_wr, buf_rd, flag_clr;
  logic       timer_tick, rx_ready, rx_valid, port_interrupt_flag, serial_clock_out;
  logic       serial_clock_oe, serial_data_output, serial_data_oe, sck, sck_drv, sdi;
  logic       ss_n, sdo_line, f_role, f_go, f_busy;
  logic [3:0] f_nbits;
  logic [7:0] ctl_wdata, sta_wdata, ctl3_wdata, rate_wdata, buf_wdata, rx_data, f_tx, f_rx;
  logic [7:0] port_control_reg_one, port_status_reg, port_control_reg_three;
  logic [7:0] rate_reload_value, port_data_buffer;
  logic [7:0] modes [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0a};
  int         halves [5] = '{2, 8, 32, 3, 6};
  int         miscompares = 0, n_compared = 0, cycles = 0, hi_run = 0, hi_len = 0, tick = 0;
  spi_master_slave_port #(.RELOAD_W(8)) i_dut (.core_clk, .rst, .ctl_wr, .ctl_wdata,
    .sta_wr, .sta_wdata, .ctl3_wr, .ctl3_wdata, .rate_wr, .rate_wdata, .buf_wr, .buf_wdata,
    .buf_rd, .flag_clr, .timer_tick, .port_control_reg_one, .port_status_reg,
    .port_control_reg_three, .rate_reload_value, .port_data_buffer, .port_interrupt_flag,
    .rx_valid, .rx_ready, .rx_data, .serial_clock_in(sck), .serial_clock_out,
    .serial_clock_oe, .serial_data_input(sdi), .serial_data_output, .serial_data_oe,
    .slave_select_input(ss_n));
  spi_far_end i_far (.core_clk, .master_role(f_role), .go(f_go), .nbits(f_nbits),
    .tx_byte(f_tx), .sck, .dev_sdo(sdo_line), .sck_drv, .sdo(sdi), .ss_n, .rx_byte(f_rx),
    .busy(f_busy));
  // shared clock line, pulled-up data line
  assign sck = serial_clock_oe ? serial_clock_out : sck_drv;
  assign sdo_line = serial_data_oe ? serial_data_output : 1'b1;
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////
  always @(posedge core_clk)
  begin
    tick <= (tick == 2) ? 0 : tick + 1;
    timer_tick <= (tick == 2);
    cycles <= cycles + 1;
    hi_run <= sck ? hi_run + 1 : 0;
    if (!sck && hi_run != 0)
      hi_len <= hi_run;
    if (cycles == 20000)
    begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // k: 0 ctl, 1 status, 2 ctl3, 3 rate, 4 data, 5 read, 6 flag clear
  task automatic sw_op(input int k, input logic [7:0] d);
    @(posedge core_clk);
    {ctl_wdata, sta_wdata, ctl3_wdata, rate_wdata, buf_wdata} <= {5{d}};
    {ctl_wr, sta_wr, ctl3_wr, rate_wr, buf_wr, buf_rd, flag_clr} <= 7'(7'h40 >> k);
    @(posedge core_clk);
    {ctl_wr, sta_wr, ctl3_wr, rate_wr, buf_wr, buf_rd, flag_clr} <= 7'h00;
    @(posedge core_clk);
    #1;
  endtask
  task automatic wait_flag();
    int n = 0;
    while (port_interrupt_flag !== 1'b1 && n < 2000)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    `CHECK(port_interrupt_flag, 1'b1)
  endtask
  task automatic far_frame(input logic [3:0] nb, input logic [7:0] tx);
    int n = 0;
    {f_nbits, f_tx, f_go} <= {nb, tx, 1'b1};
    @(posedge core_clk);
    f_go <= 1'b0;
    @(posedge core_clk);
    #1;
    while (f_busy && n < 500)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
  endtask
  task automatic m_xfer(input logic [7:0] dv, input logic [7:0] fr, input logic hit);
    far_frame(4'h8, fr);
    sw_op(4, dv);
    if (hit)
      sw_op(4, ~dv);
    wait_flag();
    `CHECK(port_data_buffer, fr)
    `CHECK(port_status_reg[0], 1'b1)
    `CHECK(f_rx, dv)
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    {ctl_wr, sta_wr, ctl3_wr, rate_wr, buf_wr, buf_rd, flag_clr, f_go, f_role} = '0;
    {ctl_wdata, sta_wdata, ctl3_wdata, rate_wdata, buf_wdata, f_tx} = '0;
    {timer_tick, rx_ready, f_nbits, rst} = {1'b0, 1'b1, 4'h8, 1'b1};
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    `CHECK({port_control_reg_one, port_status_reg, port_data_buffer}, 24'h0)
    `CHECK({port_interrupt_flag, rx_valid, serial_data_oe, serial_clock_oe}, 4'h0)
    sw_op(1, 8'hff);
    `CHECK(port_status_reg, 8'hc0)
    sw_op(1, 8'h40);
    // every master rate, one collision on the first
    for (int i = 0; i < 5; i++)
    begin
      sw_op(3, 8'h02);
      `CHECK(rate_reload_value, 8'h02)
      sw_op(0, 8'h20 | modes[i]);
      `CHECK({port_control_reg_one, serial_clock_oe}, {8'h20 | modes[i], 1'b1})
      sw_op(1, 8'h80);
      `CHECK(port_status_reg, 8'h40)
      m_xfer(8'(8'h3c + i), 8'(8'h96 ^ i), i == 0);
      `CHECK(port_control_reg_one[7], i == 0)
      sw_op(0, 8'h20 | modes[i]);
      sw_op(5, 8'h00);
      `CHECK({port_status_reg[0], port_interrupt_flag}, 2'h1)
      `CHECK(hi_len, halves[i])
      sw_op(6, 8'h00);
      sw_op(0, 8'h00);
      `CHECK(serial_data_oe, 1'b0)
    end
    // overwrite on, receive stream stalled until full
    rx_ready <= 1'b0;
    sw_op(2, 8'h10);
    `CHECK(port_control_reg_three, 8'h10)
    sw_op(0, 8'h20);
    for (int i = 0; i < 3; i++)
    begin
      m_xfer(8'(8'h11 * i), 8'(8'ha0 + i), 1'b0);
      sw_op(6, 8'h00);
    end
    `CHECK(port_control_reg_one[6], 1'b1)
    for (int i = 0; i < 3; i++)
    begin
      `CHECK({rx_valid, rx_data}, {1'b1, 8'(8'ha0 + i)})
      @(posedge core_clk);
      rx_ready <= 1'b1;
      @(posedge core_clk);
      rx_ready <= 1'b0;
      #1;
    end
    `CHECK(rx_valid, 1'b0)
    // slave with select control; a cut frame must not shift alignment
    {rx_ready, f_role} <= 2'h3;
    sw_op(0, 8'h00);
    sw_op(5, 8'h00);
    sw_op(0, 8'h24);
    `CHECK({serial_clock_oe, serial_data_oe}, 2'h0)
    for (int i = 0; i < 3; i++)
    begin
      sw_op(4, 8'(8'h5a + i));
      far_frame((i == 1) ? 4'h3 : 4'h8, 8'(8'hc3 - i));
      if (i == 1)
      begin
        repeat (4) @(posedge core_clk);
        #1;
        `CHECK({port_interrupt_flag, serial_data_oe}, 2'h0)
        continue;
      end
      wait_flag();
      `CHECK(port_data_buffer, 8'(8'hc3 - i))
      `CHECK(f_rx, 8'(8'h5a + i))
      sw_op(5, 8'h00);
      sw_op(6, 8'h00);
    end
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
